// ---- src/rcal_regs.sv ----
// Calendar, hour scale, day_of_week_index, alarm and leap-year registers of the
// real-time clock, with a password-gated write window.
// Assumes a same-clock register master: one-cycle strobes, read data
// taken in the cycle after the read strobe.
`timescale 1ns/1ns
`default_nettype none

`include "rcal_map.svh"

module rcal_regs #(
  parameter int SEC_CYCLES = `RCAL_SEC_NS / `RCAL_CLK_NS
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             alarm_match_o,
  output logic             access_open_o
);
  import rcal_pkg::*;

  // ==========================================================
  // Field packing
  function automatic logic [31:0] date_word(input rcal_date_t v);
    logic [31:0] w;
    w = '0;
    w[`RCAL_DEC_LSB +: 4] = v.decade_digit;
    w[`RCAL_YR_LSB +: 4]  = v.year_ones_digit;
    w[`RCAL_MT_LSB]       = v.cal_m_tens_digit;
    w[`RCAL_MO_LSB +: 4]  = v.cal_m_ones_digit;
    w[`RCAL_DT_LSB +: 2]  = v.d_tens_digit;
    w[`RCAL_DO_LSB +: 4]  = v.d_ones_digit;
    return w;
  endfunction

  function automatic rcal_date_t word_date(input logic [31:0] w);
    rcal_date_t v;
    v.decade_digit     = w[`RCAL_DEC_LSB +: 4];
    v.year_ones_digit  = w[`RCAL_YR_LSB +: 4];
    v.cal_m_tens_digit = w[`RCAL_MT_LSB];
    v.cal_m_ones_digit = w[`RCAL_MO_LSB +: 4];
    v.d_tens_digit     = w[`RCAL_DT_LSB +: 2];
    v.d_ones_digit     = w[`RCAL_DO_LSB +: 4];
    return v;
  endfunction

  function automatic logic [31:0] time_word(input rcal_time_t v);
    logic [31:0] w;
    w = '0;
    w[`RCAL_HT_LSB +: 2] = v.h_tens_digit;
    w[`RCAL_HO_LSB +: 4] = v.h_ones_digit;
    w[`RCAL_NT_LSB +: 3] = v.m_tens_digit;
    w[`RCAL_NO_LSB +: 4] = v.m_ones_digit;
    w[`RCAL_ST_LSB +: 3] = v.s_tens_digit;
    w[`RCAL_SO_LSB +: 4] = v.s_ones_digit;
    return w;
  endfunction

  function automatic rcal_time_t word_time(input logic [31:0] w);
    rcal_time_t v;
    v.h_tens_digit = w[`RCAL_HT_LSB +: 2];
    v.h_ones_digit = w[`RCAL_HO_LSB +: 4];
    v.m_tens_digit = w[`RCAL_NT_LSB +: 3];
    v.m_ones_digit = w[`RCAL_NO_LSB +: 4];
    v.s_tens_digit = w[`RCAL_ST_LSB +: 3];
    v.s_ones_digit = w[`RCAL_SO_LSB +: 4];
    return v;
  endfunction

  // ==========================================================
  // State
  typedef struct packed {
    rcal_run_t   run;
    logic        access_open;
    logic [9:0]  access_cnt;
    logic [24:0] presc;
    logic        tick;
    rcal_date_t  cal;
    logic        hour24;
    logic [2:0]  wday;
    rcal_time_t  talm;
    rcal_date_t  calm;
    logic        leap;
    logic        alarm_en;
    logic        alarm_flag;
    logic        match_prev;
    logic [31:0] rdata;
  } rcal_state_t;

  localparam rcal_state_t RST = '{
    run:         RUN_RESET,
    access_open: 1'b0,
    access_cnt:  10'h000,
    presc:       25'h0000000,
    tick:        1'b0,
    cal:         word_date(`RCAL_CAL_RST),
    hour24:      1'b1,
    wday:        3'h6,
    talm:        word_time(`RCAL_TALM_RST),
    calm:        word_date(`RCAL_CALM_RST),
    leap:        1'b0,
    alarm_en:    1'b0,
    alarm_flag:  1'b0,
    match_prev:  1'b0,
    rdata:       32'h00000000
  };

  localparam logic [24:0] SEC_LAST = 25'(SEC_CYCLES - 1);
  localparam logic [9:0]  ACC_LAST = 10'(`RCAL_ACCESS_CYC - 1);

  rcal_state_t q;
  rcal_state_t d;

  // ==========================================================
  // Decode helpers shared by the write and read paths
  logic       wr_open;
  logic       time_load;
  rcal_time_t time_now;
  logic       day_roll;
  rcal_date_t cal_next;
  logic       leap_now;
  logic       match_now;

  // Protected writes need the open window
  assign wr_open   = wr_i && q.access_open;
  assign time_load = wr_open && (addr_i == `RCAL_OFS_TIME);

  // Running time and date against both alarm settings
  assign match_now = (time_now == q.talm) && (q.cal == q.calm);

  // ==========================================================
  // Time counter and date stepper
  rcal_time_cnt u_time (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .tick_i     (q.tick),
    .hour24_i   (q.hour24),
    .load_i     (time_load),
    .load_val_i (word_time(wdata_i)),
    .time_o     (time_now),
    .day_roll_o (day_roll)
  );

  rcal_date_step u_date (
    .date_i      (q.cal),
    .date_next_o (cal_next),
    .leap_o      (leap_now)
  );

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    d.tick  = 1'b0;
    d.rdata = 32'h00000000;

    // Alarm registers read zero until two cycles after reset release
    case (q.run)
      RUN_RESET:  d.run = RUN_WAKE;
      RUN_WAKE:   d.run = RUN_ACTIVE;
      RUN_ACTIVE: d.run = RUN_ACTIVE;
      default:    d.run = RUN_RESET;
    endcase

    // Second prescaler; a time load restarts the second
    if (time_load || q.presc >= SEC_LAST) begin
      d.presc = 25'h0000000;
      d.tick  = !time_load;
    end else begin
      d.presc = q.presc + 25'h0000001;
    end

    // Window closes itself after its last cycle
    if (q.access_open) begin
      if (q.access_cnt == ACC_LAST) begin
        d.access_open = 1'b0;
        d.access_cnt  = 10'h000;
      end else begin
        d.access_cnt = q.access_cnt + 10'h001;
      end
    end

    // Day rollover carries into date and day_of_week_index
    if (day_roll) begin
      d.cal  = cal_next;
      d.wday = (q.wday >= 3'h6) ? 3'h0 : q.wday + 3'h1;
    end

    // Leap bit follows the stored year
    d.leap = leap_now;

    // Alarm sets on the first cycle of a match
    d.match_prev = match_now;

    // Register writes; a write beats the rollover
    if (wr_i) begin
      case (addr_i)
        `RCAL_OFS_ACCESS: begin
          // Wrong password shuts the window at once
          d.access_open = (wdata_i[15:0] == `RCAL_PASSWORD);
          d.access_cnt  = 10'h000;
        end
        `RCAL_OFS_CAL: begin
          if (wr_open) begin
            d.cal = word_date(wdata_i);
          end
        end
        `RCAL_OFS_FMT: begin
          d.hour24 = wdata_i[0];
        end
        `RCAL_OFS_WDAY: begin
          if (wr_open) begin
            d.wday = wdata_i[2:0];
          end
        end
        `RCAL_OFS_TALM: begin
          if (wr_open) begin
            d.talm = word_time(wdata_i);
          end
        end
        `RCAL_OFS_CALM: begin
          if (wr_open) begin
            d.calm = word_date(wdata_i);
          end
        end
        `RCAL_OFS_IEN: begin
          d.alarm_en = wdata_i[0];
        end
        `RCAL_OFS_ISTS: begin
          if (wdata_i[0]) begin
            d.alarm_flag = 1'b0;
          end
        end
        default: begin
          // Leap register and holes ignore writes
        end
      endcase
    end

    // Set after clear so a match in the clear cycle is kept
    if (q.alarm_en && match_now && !q.match_prev) begin
      d.alarm_flag = 1'b1;
    end

    // Read data for the next cycle; holes read zero
    if (rd_i) begin
      case (addr_i)
        `RCAL_OFS_ACCESS: d.rdata[`RCAL_OPEN_BIT] = q.access_open;
        `RCAL_OFS_TIME:   d.rdata = time_word(time_now);
        `RCAL_OFS_CAL:    d.rdata = date_word(q.cal);
        `RCAL_OFS_FMT:    d.rdata[0] = q.hour24;
        `RCAL_OFS_WDAY:   d.rdata[2:0] = q.wday;
        `RCAL_OFS_TALM: begin
          if (q.run == RUN_ACTIVE) begin
            d.rdata = time_word(q.talm);
          end
        end
        `RCAL_OFS_CALM: begin
          if (q.run == RUN_ACTIVE) begin
            d.rdata = date_word(q.calm);
          end
        end
        `RCAL_OFS_LEAP:   d.rdata[0] = q.leap;
        `RCAL_OFS_IEN:    d.rdata[0] = q.alarm_en;
        `RCAL_OFS_ISTS:   d.rdata[0] = q.alarm_flag;
        default:          d.rdata = 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state
  assign rdata_o       = q.rdata;
  assign alarm_match_o = q.alarm_flag;
  assign access_open_o = q.access_open;

endmodule

`default_nettype wire

// ---- include/rcal_map.svh ----
// Register offsets, field positions, reset values and timing counts
// for the calendar and alarm register block.
// Assumes byte addresses relative to the block base, one word each.
`ifndef RCAL_MAP_SVH
`define RCAL_MAP_SVH

// ==========================================================
// Register offsets
`define RCAL_OFS_ACCESS  12'h004
`define RCAL_OFS_TIME    12'h00c
`define RCAL_OFS_CAL     12'h010
`define RCAL_OFS_FMT     12'h014
`define RCAL_OFS_WDAY    12'h018
`define RCAL_OFS_TALM    12'h01c
`define RCAL_OFS_CALM    12'h020
`define RCAL_OFS_LEAP    12'h024
`define RCAL_OFS_IEN     12'h028
`define RCAL_OFS_ISTS    12'h02c

// ==========================================================
// Reset values
`define RCAL_CAL_RST     32'h00050101
`define RCAL_FMT_RST     32'h00000001
`define RCAL_WDAY_RST    32'h00000006
`define RCAL_TALM_RST    32'h00000000
`define RCAL_CALM_RST    32'h00000000

// ==========================================================
// Field positions (same for count and alarm registers)
`define RCAL_DEC_LSB     20
`define RCAL_YR_LSB      16
`define RCAL_MT_LSB      12
`define RCAL_MO_LSB      8
`define RCAL_DT_LSB      4
`define RCAL_DO_LSB      0
`define RCAL_HT_LSB      20
`define RCAL_HO_LSB      16
`define RCAL_NT_LSB      12
`define RCAL_NO_LSB      8
`define RCAL_ST_LSB      4
`define RCAL_SO_LSB      0
`define RCAL_OPEN_BIT    16

// ==========================================================
// Access window and timing
`define RCAL_PASSWORD    16'ha965
`define RCAL_ACCESS_CYC  512
`define RCAL_SEC_NS      1000000000
`define RCAL_CLK_NS      40

`endif

// ---- include/rcal_pkg.sv ----
// Types shared by the calendar and alarm register block.
// Assumes rcal_map.svh is on the include path.
`default_nettype none

package rcal_pkg;

  // ========================================================
  // Carriers
  typedef struct packed {
    logic [1:0] h_tens_digit;
    logic [3:0] h_ones_digit;
    logic [2:0] m_tens_digit;
    logic [3:0] m_ones_digit;
    logic [2:0] s_tens_digit;
    logic [3:0] s_ones_digit;
  } rcal_time_t;

  typedef struct packed {
    logic [3:0] decade_digit;
    logic [3:0] year_ones_digit;
    logic       cal_m_tens_digit;
    logic [3:0] cal_m_ones_digit;
    logic [1:0] d_tens_digit;
    logic [3:0] d_ones_digit;
  } rcal_date_t;

  // ========================================================
  // Run state after reset
  typedef enum logic [1:0] {
    RUN_RESET  = 2'b00,
    RUN_WAKE   = 2'b01,
    RUN_ACTIVE = 2'b11
  } rcal_run_t;

endpackage

`default_nettype wire

// ---- src/rcal_date_step.sv ----
// Next-date and leap-year logic for the BCD calendar.
// Assumes valid BCD input; out-of-range digits roll over early.
`timescale 1ns/1ns
`default_nettype none

module rcal_date_step (
  input  wire rcal_pkg::rcal_date_t date_i,
  output rcal_pkg::rcal_date_t      date_next_o,
  output logic                      leap_o
);
  import rcal_pkg::*;

  // ========================================================
  // Leap year and month length
  always_comb begin
    logic [5:0] mon;
    logic [5:0] day;
    logic [5:0] last;
    mon  = {1'b0, date_i.cal_m_tens_digit, date_i.cal_m_ones_digit};
    day  = {date_i.d_tens_digit, date_i.d_ones_digit};
    last = 6'h31;
    // Year divisible by four, years 00..99 only
    if (date_i.decade_digit[0]) begin
      leap_o = (date_i.year_ones_digit == 4'h2) ||
               (date_i.year_ones_digit == 4'h6);
    end else begin
      leap_o = (date_i.year_ones_digit == 4'h0) ||
               (date_i.year_ones_digit == 4'h4) ||
               (date_i.year_ones_digit == 4'h8);
    end
    case (mon)
      6'h02: last = leap_o ? 6'h29 : 6'h28;
      6'h04, 6'h06, 6'h09, 6'h11: last = 6'h30;
      default: last = 6'h31;
    endcase
    // Day, then month, then year carry
    date_next_o = date_i;
    if (day >= last) begin
      date_next_o.d_tens_digit = 2'h0;
      date_next_o.d_ones_digit = 4'h1;
      if (mon >= 6'h12) begin
        date_next_o.cal_m_tens_digit = 1'b0;
        date_next_o.cal_m_ones_digit = 4'h1;
        if (date_i.year_ones_digit >= 4'h9) begin
          date_next_o.year_ones_digit = 4'h0;
          date_next_o.decade_digit = (date_i.decade_digit >= 4'h9) ?
            4'h0 : date_i.decade_digit + 4'h1;
        end else begin
          date_next_o.year_ones_digit = date_i.year_ones_digit + 4'h1;
        end
      end else if (date_i.cal_m_ones_digit >= 4'h9) begin
        date_next_o.cal_m_tens_digit = 1'b1;
        date_next_o.cal_m_ones_digit = 4'h0;
      end else begin
        date_next_o.cal_m_ones_digit = date_i.cal_m_ones_digit + 4'h1;
      end
    end else if (date_i.d_ones_digit >= 4'h9) begin
      date_next_o.d_tens_digit = date_i.d_tens_digit + 2'h1;
      date_next_o.d_ones_digit = 4'h0;
    end else begin
      date_next_o.d_ones_digit = date_i.d_ones_digit + 4'h1;
    end
  end

endmodule

`default_nettype wire

// ---- src/rcal_time_cnt.sv ----
// BCD time-of-day counter with 12 and 24 hour scales.
// Assumes a one-cycle second tick on the same clock.
`timescale 1ns/1ns
`default_nettype none

module rcal_time_cnt (
  input  wire logic                 clk_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 tick_i,
  input  wire logic                 hour24_i,
  input  wire logic                 load_i,
  input  wire rcal_pkg::rcal_time_t load_val_i,
  output rcal_pkg::rcal_time_t      time_o,
  output logic                      day_roll_o
);
  import rcal_pkg::*;

  typedef struct packed {
    rcal_time_t tm;
    logic       roll;
  } rcal_tc_state_t;

  rcal_tc_state_t q;
  rcal_tc_state_t d;

  // Digit step: {carry, next}; values at or past the limit wrap
  function automatic logic [4:0] dstep(input logic [3:0] v,
                                       input logic [3:0] lim);
    return (v >= lim) ? 5'h10 : {1'b0, v + 4'h1};
  endfunction

  // Hour step: {day wrap, next hour as tens:ones}
  function automatic logic [6:0] hstep(input logic [5:0] h,
                                       input logic       h24);
    logic [6:0] r;
    r = {1'b0, h[5:4], h[3:0] + 4'h1};
    if (h24) begin
      if (h >= 6'h23) begin
        r = 7'h40;
      end else if (h[3:0] >= 4'h9) begin
        r = {1'b0, h[5:4] + 2'h1, 4'h0};
      end
    end else begin
      // AM 01..12, PM 21..32; 12 AM is midnight
      case (h)
        6'h11: r = 7'h32;
        6'h31: r = 7'h52;
        6'h32: r = 7'h21;
        6'h12: r = 7'h01;
        6'h09: r = 7'h10;
        6'h29: r = 7'h30;
        default: r = {1'b0, h[5:4], h[3:0] + 4'h1};
      endcase
    end
    return r;
  endfunction

  // ========================================================
  // Next state: a load wins over a tick in the same cycle
  always_comb begin
    logic [4:0] c;
    logic [6:0] hr;
    c  = '0;
    hr = '0;
    d = q;
    d.roll = 1'b0;
    if (load_i) begin
      d.tm = load_val_i;
    end else if (tick_i) begin
      c = dstep(q.tm.s_ones_digit, 4'h9);
      d.tm.s_ones_digit = c[3:0];
      if (c[4]) begin
        c = dstep({1'b0, q.tm.s_tens_digit}, 4'h5);
        d.tm.s_tens_digit = c[2:0];
      end
      if (c[4]) begin
        c = dstep(q.tm.m_ones_digit, 4'h9);
        d.tm.m_ones_digit = c[3:0];
      end
      if (c[4]) begin
        c = dstep({1'b0, q.tm.m_tens_digit}, 4'h5);
        d.tm.m_tens_digit = c[2:0];
      end
      if (c[4]) begin
        hr = hstep({q.tm.h_tens_digit, q.tm.h_ones_digit}, hour24_i);
        d.tm.h_tens_digit = hr[5:4];
        d.tm.h_ones_digit = hr[3:0];
        d.roll = hr[6];
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign time_o     = q.tm;
  assign day_roll_o = q.roll;

endmodule

`default_nettype wire

// ---- test/rcal_regs_props.sv ----
// Concurrent checks on the ports of the calendar and alarm registers.
// Assumes it is bound to rcal_regs and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none

module rcal_regs_props #(
  parameter int SEC_CYCLES = 8
) (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        alarm_match_o,
  input wire logic        access_open_o
);
  localparam int OPEN_CYC = 512;
  logic       fmt_q;
  logic [9:0] open_cnt_q;
  logic       pw_wr;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // ========================================================
  // Helper logic
  // Password write, which opens or restarts the window
  assign pw_wr = wr_i && addr_i == 12'h004 && wdata_i[15:0] == 16'ha965;

  // Scale bit shadow and cycles the window has stood open
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fmt_q      <= 1'b1;
      open_cnt_q <= 10'h000;
    end else begin
      if (wr_i && addr_i == 12'h014) begin
        fmt_q <= wdata_i[0];
      end
      // Counts on past 512 so a window that never closes is caught
      if (pw_wr) begin
        open_cnt_q <= 10'h001;
      end else if (access_open_o) begin
        open_cnt_q <= open_cnt_q + 10'h001;
      end else begin
        open_cnt_q <= 10'h000;
      end
    end
  end

  // ========================================================
  // Assertions
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  open_set_a: assert property (pw_wr |=> access_open_o)
    else $error("password did not open the window");
  open_clear_a: assert property (wr_i && addr_i == 12'h004 &&
    wdata_i[15:0] != 16'ha965 |=> !access_open_o)
    else $error("other value did not close the window");
  open_max_a: assert property (
    access_open_o |-> open_cnt_q <= OPEN_CYC)
    else $error("window stayed open too long");
  open_hold_a: assert property (access_open_o && !wr_i &&
    open_cnt_q < OPEN_CYC |=> access_open_o)
    else $error("window closed early");
  open_read_a: assert property (rd_i && addr_i == 12'h004 |=>
    rdata_o == {15'h0, $past(access_open_o), 16'h0})
    else $error("access register read wrong");
  fmt_read_a: assert property (rd_i && addr_i == 12'h014 |=>
    rdata_o == {31'h0, $past(fmt_q)})
    else $error("hour scale read wrong");
  leap_res_a: assert property (rd_i && addr_i == 12'h024 |=>
    rdata_o[31:1] == 31'h0)
    else $error("leap register reserved bits set");
  unmapped_rd_a: assert property (rd_i && addr_i > 12'h02c |=>
    rdata_o == 32'h0)
    else $error("unmapped read not zero");
  date_res_a: assert property (rd_i && (addr_i == 12'h010 ||
    addr_i == 12'h020) |=> rdata_o[31:24] == 8'h00 &&
    rdata_o[15:13] == 3'h0 && rdata_o[7:6] == 2'h0)
    else $error("date reserved bits set");
  alarm_clear_a: assert property (alarm_match_o && wr_i &&
    addr_i == 12'h02c && wdata_i[0] |=> !alarm_match_o)
    else $error("alarm flag not cleared");
  ists_read_a: assert property (rd_i && addr_i == 12'h02c |=>
    rdata_o == {31'h0, $past(alarm_match_o)})
    else $error("alarm status read wrong");

  // Main scenarios reached
  cov_open_c: cover property (pw_wr ##1 access_open_o);
  cov_alarm_c: cover property ($rose(alarm_match_o));
  cov_expire_c: cover property ($fell(access_open_o) && !wr_i);
endmodule

bind rcal_regs rcal_regs_props #(.SEC_CYCLES(SEC_CYCLES)) u_props (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .alarm_match_o(alarm_match_o), .access_open_o(access_open_o)
);

`default_nettype wire

// ---- test/test_rcal_regs.sv ----
// Self-checking bench for the calendar and alarm register block.
// Assumes rcal_regs with a short second prescaler and the checker bound.
`timescale 1ns/1ns
`default_nettype none

module test_rcal_regs;
  localparam int SEC = 8;
  typedef struct packed {
    logic        wr;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } rcal_row_t;
  // Ordinary accesses: write, or read with expected word
  localparam rcal_row_t ROWS [24] = '{
    '{1'b0, 12'h010, 32'h0, 32'h00050101},
    '{1'b0, 12'h014, 32'h0, 32'h00000001},
    '{1'b0, 12'h018, 32'h0, 32'h00000006},
    '{1'b0, 12'h01c, 32'h0, 32'h00000000},
    '{1'b0, 12'h020, 32'h0, 32'h00000000},
    '{1'b0, 12'h024, 32'h0, 32'h00000000},
    '{1'b1, 12'h010, 32'h00991231, 32'h0},
    '{1'b0, 12'h010, 32'h0, 32'h00050101},
    '{1'b1, 12'h004, 32'h0000a965, 32'h0},
    '{1'b0, 12'h004, 32'h0, 32'h00010000},
    '{1'b1, 12'h010, 32'h00240229, 32'h0},
    '{1'b1, 12'h018, 32'h00000003, 32'h0},
    '{1'b0, 12'h010, 32'h0, 32'h00240229},
    '{1'b0, 12'h024, 32'h0, 32'h00000001},
    '{1'b1, 12'h024, 32'h0, 32'h0},
    '{1'b0, 12'h024, 32'h0, 32'h00000001},
    '{1'b0, 12'h018, 32'h0, 32'h00000003},
    '{1'b1, 12'h01c, 32'h00235959, 32'h0},
    '{1'b0, 12'h01c, 32'h0, 32'h00235959},
    '{1'b1, 12'h020, 32'h00991231, 32'h0},
    '{1'b0, 12'h020, 32'h0, 32'h00991231},
    '{1'b1, 12'h014, 32'h0, 32'h0},
    '{1'b0, 12'h014, 32'h0, 32'h0},
    '{1'b0, 12'h100, 32'h0, 32'h0}};
  localparam logic [31:0] HM = 32'h003f7f00;
  localparam logic [31:0] ALL = 32'hffffffff;

  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic        alarm_match_o;
  logic        access_open_o;
  int          failures = 0;
  int          samples_checked = 0;

  rcal_regs #(.SEC_CYCLES(SEC)) u_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .alarm_match_o(alarm_match_o), .access_open_o(access_open_o));

  // ========================================================
  // Clock and helpers
  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Each access ends one idle cycle later, so strobes never double up
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    logic [31:0] v;
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
    chk(v & m, e);
    @(posedge clk_i);
  endtask

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Cuts a hang short well past the expected run of some 700 cycles
  initial begin
    #(40 * 6000);
    failures++;
    give_verdict();
  end

  // ========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 24; i++) begin
      if (ROWS[i].wr) begin
        bus_wr(ROWS[i].a, ROWS[i].d);
      end else begin
        rd_chk(ROWS[i].a, ALL, ROWS[i].e);
      end
    end
    // Any other value closes the window at once, then reopen it
    bus_wr(12'h004, 32'h00001234);
    chk({31'h0, access_open_o}, 32'h0);
    bus_wr(12'h004, 32'h0000a965);
    // 24 hour midnight in a leap February, Saturday to Sunday
    bus_wr(12'h014, 32'h1);
    bus_wr(12'h010, 32'h00240228);
    bus_wr(12'h018, 32'h6);
    bus_wr(12'h00c, 32'h00235959);
    repeat (SEC + 4) @(posedge clk_i);
    rd_chk(12'h00c, HM, 32'h0);
    rd_chk(12'h010, 32'hffffffff, 32'h00240229);
    rd_chk(12'h018, 32'hffffffff, 32'h0);
    // 12 hour steps: 11 AM to noon, 11 PM to 12 AM with a month carry
    bus_wr(12'h014, 32'h0);
    bus_wr(12'h00c, 32'h00115959);
    repeat (SEC + 4) @(posedge clk_i);
    rd_chk(12'h00c, HM, 32'h00320000);
    bus_wr(12'h00c, 32'h00315959);
    repeat (SEC + 4) @(posedge clk_i);
    rd_chk(12'h00c, HM, 32'h00120000);
    rd_chk(12'h010, 32'hffffffff, 32'h00240301);
    // Alarm two seconds ahead, then write-one clear
    bus_wr(12'h014, 32'h1);
    bus_wr(12'h028, 32'h1);
    bus_wr(12'h020, 32'h00240301);
    bus_wr(12'h01c, 32'h00101002);
    bus_wr(12'h00c, 32'h00101000);
    repeat (3 * SEC + 4) @(posedge clk_i);
    chk({31'h0, alarm_match_o}, 32'h1);
    rd_chk(12'h02c, 32'hffffffff, 32'h1);
    bus_wr(12'h02c, 32'h1);
    rd_chk(12'h02c, 32'hffffffff, 32'h0);
    // Window runs out by itself; protected writes then bounce
    bus_wr(12'h004, 32'h0000a965);
    repeat (515) @(posedge clk_i);
    chk({31'h0, access_open_o}, 32'h0);
    bus_wr(12'h018, 32'h5);
    bus_wr(12'h010, 32'h00990101);
    rd_chk(12'h018, 32'hffffffff, 32'h1);
    rd_chk(12'h010, 32'hffffffff, 32'h00240301);
    // Second reset in mid-run restores the alarm and date words
    arst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({30'h0, access_open_o, alarm_match_o}, 32'h0);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd_chk(12'h01c, 32'hffffffff, 32'h0);
    rd_chk(12'h010, 32'hffffffff, 32'h00050101);
    give_verdict();
  end
endmodule

`default_nettype wire
